// file: logic/mclk_lossdet_pkg.sv
// Constants, register map and carrier types for the clock select and loss detect block.
package mclk_lossdet_pkg;

  localparam int NUM_CH = 4;

  // Register byte offsets on the APB slave.
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_INT_EN = 12'h008;
  localparam logic [11:0] ADDR_INT_CLR = 12'h00C;
  localparam logic [11:0] ADDR_MCLK = 12'h010;

  // Control word: bits [2:0] ref select, [3] rate, [4] extended loss, [9:5] equalizer, [10] decode, [14:11] rx on.
  typedef struct packed {
    logic [3:0] rx_channel_on;
    logic decode_select;
    logic [4:0] equalizer_control;
    logic extended_loss_window;
    logic output_rate_select;
    logic [2:0] ref_rate_select;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 15'h0000;
  localparam logic [3:0] INT_EN_RESET = 4'h0;

  // Equalizer control bit that selects E1 operation.
  localparam int EQ_E1_BIT = 4;

  // Synthesizer setting handed to the analog clock multiplier.
  typedef struct packed {
    logic [1:0] src;
    logic [11:0] ref_khz;
    logic [11:0] out_khz;
  } mclk_cfg_t;

  localparam logic [1:0] SRC_E1_IN = 2'h0;
  localparam logic [1:0] SRC_T1_IN = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;

  localparam logic [11:0] KHZ_E1 = 12'h800;
  localparam logic [11:0] KHZ_T1 = 12'h608;
  localparam logic [11:0] KHZ_8 = 12'h008;
  localparam logic [11:0] KHZ_16 = 12'h010;
  localparam logic [11:0] KHZ_56 = 12'h038;
  localparam logic [11:0] KHZ_64 = 12'h040;
  localparam logic [11:0] KHZ_128 = 12'h080;
  localparam logic [11:0] KHZ_256 = 12'h100;
  localparam mclk_cfg_t MCLK_RESET = {SRC_E1_IN, KHZ_E1, KHZ_E1};

  // Loss detector thresholds, in received bits.
  localparam logic [12:0] ZEROS_E1 = 13'h0020;
  localparam logic [12:0] ZEROS_E1_EXT = 13'h1000;
  localparam logic [12:0] ZEROS_T1 = 13'h00AF;
  localparam logic [7:0] WIN_E1 = 8'h20;
  localparam logic [7:0] WIN_T1 = 8'h80;
  localparam logic [7:0] ONES_E1 = 8'h04;
  localparam logic [7:0] ONES_T1 = 8'h10;
  localparam logic [7:0] RUN_E1 = 8'h10;
  localparam logic [7:0] RUN_T1 = 8'h64;

  typedef enum logic {
    ST_WATCH,
    ST_LOST
  } los_state_t;

endpackage : mclk_lossdet_pkg

// file: logic/loss_detector.sv
// Digital half of the receive loss-of-signal detector for one channel.
`timescale 1ns/1ps
module loss_detector (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_bit_valid,
  input wire logic i_bit_one,
  input wire logic i_analog_loss,
  input wire logic i_e1_mode,
  input wire logic i_ext_loss,
  output logic o_loss
);
  import mclk_lossdet_pkg::*;

  los_state_t state_q, state_d;
  logic [12:0] zeros_q, zeros_d;
  logic [7:0] win_q, win_d;
  logic [7:0] ones_q, ones_d;
  logic [7:0] run_q, run_d;
  logic bad_q, bad_d;
  logic [12:0] thr;
  logic [7:0] win_len, need, run_max, ones_n, run_n;
  logic bad_n;

  // Thresholds follow the line rate; the window is judged including the bit that closes it.
  always_comb begin
    thr = i_e1_mode ? (i_ext_loss ? ZEROS_E1_EXT : ZEROS_E1) : ZEROS_T1;
    win_len = i_e1_mode ? WIN_E1 : WIN_T1;
    need = i_e1_mode ? ONES_E1 : ONES_T1;
    run_max = i_e1_mode ? RUN_E1 : RUN_T1;
    ones_n = ones_q + {7'h00, i_bit_one};
    run_n = i_bit_one ? 8'h00 : ((run_q == 8'hFF) ? run_q : run_q + 8'h01);
    bad_n = bad_q | (run_n > run_max);
    state_d = state_q;
    zeros_d = zeros_q;
    win_d = win_q;
    ones_d = ones_q;
    run_d = run_q;
    bad_d = bad_q;
    case (state_q)
      ST_WATCH: begin
        win_d = 8'h00;
        ones_d = 8'h00;
        run_d = 8'h00;
        bad_d = 1'b0;
        if (!i_enable || !i_analog_loss) begin
          zeros_d = 13'h0000;
        end else if (i_bit_valid) begin
          if (i_bit_one) begin
            zeros_d = 13'h0000;
          end else if (zeros_q == thr - 13'h0001) begin
            zeros_d = 13'h0000;
            state_d = ST_LOST;
          end else begin
            zeros_d = zeros_q + 13'h0001;
          end
        end
      end
      ST_LOST: begin
        if (!i_enable) begin
          state_d = ST_WATCH;
        end else if (i_bit_valid) begin
          if (win_q == win_len - 8'h01) begin
            // Clearing needs the analog side recovered as well as a good window.
            if (!i_analog_loss && !bad_n && ones_n >= need) begin
              state_d = ST_WATCH;
            end
            win_d = 8'h00;
            ones_d = 8'h00;
            run_d = 8'h00;
            bad_d = 1'b0;
          end else begin
            win_d = win_q + 8'h01;
            ones_d = ones_n;
            run_d = run_n;
            bad_d = bad_n;
          end
        end
      end
      default: begin
        state_d = ST_WATCH;
      end
    endcase
  end

  // State registers with synchronous reset.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q <= ST_WATCH;
      zeros_q <= 13'h0000;
      win_q <= 8'h00;
      ones_q <= 8'h00;
      run_q <= 8'h00;
      bad_q <= 1'b0;
    end else begin
      state_q <= state_d;
      zeros_q <= zeros_d;
      win_q <= win_d;
      ones_q <= ones_d;
      run_q <= run_d;
      bad_q <= bad_d;
    end
  end

  assign o_loss = (state_q == ST_LOST);

  // Checks on declaring and clearing loss.
  AST_IDLE_CLEAR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_q == ST_WATCH && !i_analog_loss) |=> (zeros_q == 13'h0000))
    else $error("zero counter not cleared without analog loss");
  AST_DECLARE_AT_THR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_q == ST_WATCH && state_d == ST_LOST) |-> (zeros_q == thr - 13'h0001 && !i_bit_one && i_analog_loss))
    else $error("loss declared at wrong zero count");
  AST_E1_CLEAR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ($fell(o_loss) && $past(i_enable) && $past(i_e1_mode)) |->
      (!$past(i_analog_loss) && ($past(ones_q) + {7'h00, $past(i_bit_one)}) >= ONES_E1 && !$past(bad_q)))
    else $error("E1 loss cleared without recovery or density");
  AST_T1_CLEAR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ($fell(o_loss) && $past(i_enable) && !$past(i_e1_mode)) |->
      (!$past(i_analog_loss) && ($past(ones_q) + {7'h00, $past(i_bit_one)}) >= ONES_T1 && !$past(bad_q)))
    else $error("T1 loss cleared without recovery or density");
  COV_DECLARE: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(o_loss));
  COV_CLEAR: cover property (@(posedge i_clock) disable iff (!i_rst_n) $fell(o_loss) && $past(i_enable));

endmodule : loss_detector

// file: logic/line_rx_loss_detect_and_mclk_select.sv
// Master clock select, receive channel enables, loss-of-signal detection and alarm interrupt.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - External references of 8 to 256 kHz on select codes 010 to 111 give 2048 kHz at rate 0 and 1544 kHz at rate 1.
// - Select codes 000 and 001 take the reference from the E1 and T1 clock inputs, rate choosing the output.
// - In host mode, reference select and output rate come from software control bits instead of pins.
// - In hardware mode every receive channel is off during reset, on from the first clock after reset and stays on.
// - In host mode each receive channel is switched by its own receive-on control bit.
// - Under analog loss, consecutive zeros are counted and loss declared after 32 (E1), 4096 (E1 extended) or 175 (T1).
// - In E1, loss clears only after analog recovery and 4 ones in a 32-bit window with no run above 16 zeros.
// - In T1, loss clears only after analog recovery and 16 ones in a 128-bit window with no run above 100 zeros.
// - A change of loss updates indication and status and, when enabled, pulls the interrupt low.
// - Reading the alarm status clears it and the interrupt returns high.
// - Received data is presented on the data and violation outputs, decoded when decoding is selected.
// - The T1 or E1 operating mode is taken from the five-bit equalizer control field.
module line_rx_loss_detect_and_mclk_select (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_host_mode,
  input wire logic [2:0] i_ref_rate_select,
  input wire logic i_output_rate_select,
  input wire logic i_extended_loss_window,
  input wire logic [4:0] i_equalizer_control,
  input wire logic i_decode_select,
  input wire logic [3:0] i_rx_bit_valid,
  input wire logic [3:0] i_rx_pos,
  input wire logic [3:0] i_rx_neg,
  input wire logic [3:0] i_rx_violation,
  input wire logic [3:0] i_analog_loss,
  output mclk_lossdet_pkg::mclk_cfg_t o_mclk_cfg,
  output logic o_e1_mode,
  output logic [3:0] o_rx_channel_on,
  output logic [3:0] o_rx_loss_of_signal,
  output logic [3:0] o_rx_pos_data_out,
  output logic [3:0] o_rx_neg_violation_out,
  output logic o_int_n
);
  import mclk_lossdet_pkg::*;

  ctrl_t ctrl_q, ctrl_d;
  logic [3:0] en_q, en_d;
  logic [3:0] status_q, status_d;
  logic [3:0] los_q, los_d;
  logic [3:0] det_loss;
  logic [3:0] ev;
  logic [3:0] clr;
  logic int_n_q, int_n_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  mclk_cfg_t mclk_q, mclk_d;
  logic e1_q, e1_d;
  logic [3:0] on_q, on_d;
  logic [3:0] pos_q, pos_d;
  logic [3:0] neg_q, neg_d;
  logic access, done, rd_status;
  logic [2:0] sel;
  logic rate, ext_eff, dec_eff;
  logic [4:0] eq_eff;

  // Host mode steers from the control register, hardware mode from the pins.
  always_comb begin
    sel = i_host_mode ? ctrl_q.ref_rate_select : i_ref_rate_select;
    rate = i_host_mode ? ctrl_q.output_rate_select : i_output_rate_select;
    ext_eff = i_host_mode ? ctrl_q.extended_loss_window : i_extended_loss_window;
    eq_eff = i_host_mode ? ctrl_q.equalizer_control : i_equalizer_control;
    dec_eff = i_host_mode ? ctrl_q.decode_select : i_decode_select;
  end

  // Synthesizer selection; the multiplier itself is analog and only reads this setting.
  always_comb begin
    mclk_d.out_khz = rate ? KHZ_T1 : KHZ_E1;
    mclk_d.src = SRC_EXT;
    mclk_d.ref_khz = KHZ_256;
    case (sel)
      3'h0: begin
        mclk_d.src = SRC_E1_IN;
        mclk_d.ref_khz = KHZ_E1;
      end
      3'h1: begin
        mclk_d.src = SRC_T1_IN;
        mclk_d.ref_khz = KHZ_T1;
      end
      3'h2: mclk_d.ref_khz = KHZ_8;
      3'h3: mclk_d.ref_khz = KHZ_16;
      3'h4: mclk_d.ref_khz = KHZ_56;
      3'h5: mclk_d.ref_khz = KHZ_64;
      3'h6: mclk_d.ref_khz = KHZ_128;
      default: mclk_d.ref_khz = KHZ_256;
    endcase
    e1_d = eq_eff[EQ_E1_BIT];
    on_d = i_host_mode ? ctrl_q.rx_channel_on : 4'hF;
  end

  // One detector per channel, fed with ones on either rail.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    loss_detector u_det (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_enable(on_q[c]),
      .i_bit_valid(i_rx_bit_valid[c]),
      .i_bit_one(i_rx_pos[c] | i_rx_neg[c]),
      .i_analog_loss(i_analog_loss[c]),
      .i_e1_mode(e1_q),
      .i_ext_loss(ext_eff),
      .o_loss(det_loss[c])
    );
  end

  // Receive outputs update on each recovered bit; a switched-off channel presents zeros.
  always_comb begin
    pos_d = pos_q;
    neg_d = neg_q;
    for (int c = 0; c < NUM_CH; c++) begin
      if (!on_q[c]) begin
        pos_d[c] = 1'b0;
        neg_d[c] = 1'b0;
      end else if (i_rx_bit_valid[c]) begin
        pos_d[c] = dec_eff ? (i_rx_pos[c] | i_rx_neg[c]) : i_rx_pos[c];
        neg_d[c] = dec_eff ? i_rx_violation[c] : i_rx_neg[c];
      end
    end
  end

  // APB slave: one wait state so that read data can come from a flop.
  always_comb begin
    access = i_psel & i_penable;
    done = access & pready_q;
    pready_d = access & !pready_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (access && !pready_q) begin
      pslverr_d = 1'b0;
      case (i_paddr)
        ADDR_CTRL: prdata_d = {17'h00000, ctrl_q};
        ADDR_STATUS: prdata_d = {23'h000000, e1_q, los_q, status_q};
        ADDR_INT_EN: prdata_d = {28'h0000000, en_q};
        ADDR_INT_CLR: prdata_d = 32'h00000000;
        ADDR_MCLK: prdata_d = {6'h00, mclk_q};
        default: begin
          prdata_d = 32'h00000000;
          pslverr_d = 1'b1;
        end
      endcase
    end
    rd_status = done & !i_pwrite & (i_paddr == ADDR_STATUS);
    ctrl_d = ctrl_q;
    en_d = en_q;
    clr = 4'h0;
    if (done && i_pwrite) begin
      case (i_paddr)
        ADDR_CTRL: ctrl_d = i_pwdata[14:0];
        ADDR_INT_EN: en_d = i_pwdata[3:0];
        ADDR_INT_CLR: clr = i_pwdata[3:0];
        default: ;
      endcase
    end
    if (rd_status) begin
      clr = 4'hF;
    end
  end

  // Alarm status: any change of loss is sticky, and a new event beats a clear in the same cycle.
  always_comb begin
    los_d = det_loss;
    ev = det_loss ^ los_q;
    status_d = (status_q & ~clr) | ev;
    int_n_d = ~|(status_d & en_d);
  end

  // All registers; every output below is a flop.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctrl_q <= CTRL_RESET;
      en_q <= INT_EN_RESET;
      status_q <= 4'h0;
      los_q <= 4'h0;
      int_n_q <= 1'b1;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      mclk_q <= MCLK_RESET;
      e1_q <= 1'b0;
      on_q <= 4'h0;
      pos_q <= 4'h0;
      neg_q <= 4'h0;
    end else begin
      ctrl_q <= ctrl_d;
      en_q <= en_d;
      status_q <= status_d;
      los_q <= los_d;
      int_n_q <= int_n_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      mclk_q <= mclk_d;
      e1_q <= e1_d;
      on_q <= on_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_mclk_cfg = mclk_q;
  assign o_e1_mode = e1_q;
  assign o_rx_channel_on = on_q;
  assign o_rx_loss_of_signal = los_q;
  assign o_rx_pos_data_out = pos_q;
  assign o_rx_neg_violation_out = neg_q;
  assign o_int_n = int_n_q;

  // Checks on configuration, data path and alarm behaviour.
  AST_EXT_REF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rst_n && (sel >= 3'h2) |=> (o_mclk_cfg.src == SRC_EXT && o_mclk_cfg.out_khz == ($past(rate) ? KHZ_T1 : KHZ_E1)))
    else $error("external reference selection wrong");
  AST_PIN_REF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rst_n && (sel == 3'h1) |=> (o_mclk_cfg.src == SRC_T1_IN && o_mclk_cfg.ref_khz == KHZ_T1))
    else $error("T1 input reference selection wrong");
  AST_HOST_SEL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rst_n && i_host_mode |=> (o_mclk_cfg.out_khz == ($past(ctrl_q.output_rate_select) ? KHZ_T1 : KHZ_E1)))
    else $error("host mode rate not taken from control");
  AST_HW_ALL_ON: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rst_n && !i_host_mode |=> (o_rx_channel_on == 4'hF))
    else $error("hardware mode channel off");
  AST_HOST_ON: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rst_n && i_host_mode |=> (o_rx_channel_on == $past(ctrl_q.rx_channel_on)))
    else $error("host channel enable mismatch");
  AST_INT_ON_EVENT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (|(ev & en_q)) && !done |=> (!o_int_n && (status_q & $past(ev)) == $past(ev)))
    else $error("enabled loss change did not raise interrupt");
  AST_READ_CLEARS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (rd_status && ev == 4'h0) |=> (status_q == 4'h0 && o_int_n))
    else $error("status read did not clear alarm");
  AST_DATA_OUT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (on_q[0] && i_rx_bit_valid[0] && !dec_eff) |=> (o_rx_pos_data_out[0] == $past(i_rx_pos[0])))
    else $error("channel data not presented");
  AST_EQ_MODE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rst_n |=> (o_e1_mode == $past(eq_eff[EQ_E1_BIT])))
    else $error("line mode not from equalizer control");
  COV_INT: cover property (@(posedge i_clock) disable iff (!i_rst_n) $fell(o_int_n));
  COV_READ_CLEAR: cover property (@(posedge i_clock) disable iff (!i_rst_n) rd_status && status_q != 4'h0);
  COV_EXT: cover property (@(posedge i_clock) disable iff (!i_rst_n) ext_eff && e1_q && |ev);

endmodule : line_rx_loss_detect_and_mclk_select

// file: dv/line_tx_model.sv
// Behavioural remote line transmitter that feeds recovered bits to all four receive channels.
`timescale 1ns/1ps
module line_tx_model (
  input wire logic i_clock,
  output logic [3:0] o_bit_valid,
  output logic [3:0] o_pos,
  output logic [3:0] o_neg,
  output logic [3:0] o_violation
);
  logic mark_q;

  // Lines idle at time zero; marks alternate polarity as they would on a real line.
  initial begin
    o_bit_valid = 4'h0;
    o_pos = 4'h0;
    o_neg = 4'h0;
    o_violation = 4'h0;
    mark_q = 1'b0;
  end

  // One strobe per bit; after the sampling edge the rails flip, so stale values never pass for data.
  task automatic send_bit(input logic p, input logic n, input logic v);
    o_bit_valid <= 4'hF;
    o_pos <= {4{p}};
    o_neg <= {4{n}};
    o_violation <= {4{v}};
    @(posedge i_clock);
    o_bit_valid <= 4'h0;
    o_pos <= {4{~p}};
    o_neg <= {4{~n}};
    o_violation <= {4{~v}};
  endtask : send_bit

  // Sends n bits, lowest first and zeros past bit 127, with one idle cycle between strobes.
  task automatic send(input logic [127:0] pat, input int n);
    logic b;
    @(posedge i_clock);
    for (int i = 0; i < n; i++) begin
      b = (i < 128) ? pat[i] : 1'b0;
      send_bit(b & ~mark_q, b & mark_q, 1'b0);
      mark_q = mark_q ^ b;
      @(posedge i_clock);
    end
  endtask : send
endmodule : line_tx_model

// file: dv/tb_top.sv
// Self-checking bench for clock select, channel enables, loss detection and the alarm interrupt.
`timescale 1ns/1ps
module tb_top;
  import mclk_lossdet_pkg::*;
  logic i_clock, i_rst_n, psel, penable, pwrite, host_mode, rate, ext, dec;
  logic pready, pslverr, e1_mode, int_n, err_q, tp, tn, tv, td;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [2:0] ref_sel;
  logic [4:0] eq;
  logic [3:0] alos, bv, pos, neg, viol, ch_on, los, pos_out, neg_out;
  logic [127:0] pat;
  mclk_cfg_t mclk;
  int error_cnt, cmp_count;

  line_rx_loss_detect_and_mclk_select uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_host_mode(host_mode), .i_ref_rate_select(ref_sel),
    .i_output_rate_select(rate), .i_extended_loss_window(ext), .i_equalizer_control(eq),
    .i_decode_select(dec), .i_rx_bit_valid(bv), .i_rx_pos(pos), .i_rx_neg(neg), .i_rx_violation(viol),
    .i_analog_loss(alos), .o_mclk_cfg(mclk), .o_e1_mode(e1_mode), .o_rx_channel_on(ch_on),
    .o_rx_loss_of_signal(los), .o_rx_pos_data_out(pos_out), .o_rx_neg_violation_out(neg_out),
    .o_int_n(int_n));

  line_tx_model u_tx (.i_clock(i_clock), .o_bit_valid(bv), .o_pos(pos), .o_neg(neg), .o_violation(viol));

  // Free-running 100 MHz clock.
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Guard against a hang anywhere in the sequence.
  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer; it always starts one edge after the call so strobes never toggle twice per step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp, what);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask : settle

  // Expected synthesizer setting for a select code and output rate.
  function automatic mclk_cfg_t exp_mclk(input logic [2:0] c, input logic r);
    exp_mclk.out_khz = r ? KHZ_T1 : KHZ_E1;
    exp_mclk.src = (c == 3'h0) ? SRC_E1_IN : (c == 3'h1) ? SRC_T1_IN : SRC_EXT;
    case (c)
      3'h0: exp_mclk.ref_khz = KHZ_E1;
      3'h1: exp_mclk.ref_khz = KHZ_T1;
      3'h2: exp_mclk.ref_khz = KHZ_8;
      3'h3: exp_mclk.ref_khz = KHZ_16;
      3'h4: exp_mclk.ref_khz = KHZ_56;
      3'h5: exp_mclk.ref_khz = KHZ_64;
      3'h6: exp_mclk.ref_khz = KHZ_128;
      default: exp_mclk.ref_khz = KHZ_256;
    endcase
  endfunction : exp_mclk

  // Main sequence: reset, hardware-mode pins, data path, E1/T1/extended loss, host mode.
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    i_rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {host_mode, ref_sel, rate, ext, dec, alos} = '0;
    // One common line rate on all channels, and one reference feeding both clock inputs.
    eq = 5'h10;
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    settle(2);
    chk({28'h0, ch_on}, 32'hF, "channels on");
    chk({31'h0, int_n}, 32'h1, "int idle");
    rd(ADDR_CTRL, 32'h0, "ctrl reset");
    rd(ADDR_INT_EN, 32'h0, "int_en reset");
    rd(ADDR_INT_CLR, 32'h0, "int_clr reads zero");
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err_q}, 32'h1, "unmapped error");
    $display("Test registers done");
    for (int c = 0; c < 16; c++) begin
      @(posedge i_clock);
      ref_sel <= c[3:1];
      rate <= c[0];
      settle(3);
      chk({6'h0, mclk}, {6'h0, exp_mclk(c[3:1], c[0])}, "mclk pins");
    end
    $display("Test clock select done");
    for (int c = 0; c < 6; c++) begin
      tp = (c % 3 == 0);
      tn = (c % 3 == 1);
      tv = (c % 3 != 0);
      td = (c > 2);
      @(posedge i_clock);
      dec <= td;
      @(posedge i_clock);
      u_tx.send_bit(tp, tn, tv);
      @(negedge i_clock);
      chk({pos_out, neg_out}, {{4{td ? tp | tn : tp}}, {4{td ? tv : tn}}}, "data path");
    end
    $display("Test data path done");
    apb(1'b1, ADDR_INT_EN, 32'h1);
    u_tx.send(128'h0, 40);
    alos <= 4'hF;
    u_tx.send(128'h0, 31);
    settle(4);
    chk(los, 4'h0, "early loss");
    u_tx.send(128'h0, 1);
    settle(4);
    chk(los, 4'hF, "E1 loss");
    chk(int_n, 1'b0, "int low");
    rd(ADDR_STATUS, 32'h1FF, "status set");
    settle(2);
    chk(int_n, 1'b1, "int released");
    rd(ADDR_STATUS, 32'h1F0, "status read clear");
    u_tx.send(128'h01010101, 32);
    alos <= 4'h0;
    u_tx.send(128'h00100007, 32);
    settle(4);
    chk(los, 4'hF, "E1 loss held");
    u_tx.send(128'h01010101, 32);
    settle(4);
    chk(los, 4'h0, "E1 loss cleared");
    chk(int_n, 1'b0, "int on clear");
    apb(1'b1, ADDR_INT_CLR, 32'hF);
    settle(2);
    chk(int_n, 1'b1, "int after clear");
    rd(ADDR_STATUS, 32'h100, "status cleared");
    $display("Test E1 loss done");
    eq <= 5'h00;
    apb(1'b1, ADDR_INT_EN, 32'h0);
    settle(2);
    chk(e1_mode, 1'b0, "T1 mode");
    @(posedge i_clock);
    alos <= 4'hF;
    u_tx.send(128'h0, 174);
    settle(4);
    chk(los, 4'h0, "T1 early loss");
    u_tx.send(128'h0, 1);
    settle(4);
    chk(los, 4'hF, "T1 loss");
    chk(int_n, 1'b1, "masked int");
    rd(ADDR_STATUS, 32'h0FF, "T1 status");
    pat = '0;
    for (int i = 0; i < 15; i++) pat[8 * i] = 1'b1;
    alos <= 4'h0;
    u_tx.send(pat, 128);
    settle(4);
    chk(los, 4'hF, "T1 loss held");
    pat[120] = 1'b1;
    u_tx.send(pat, 128);
    settle(4);
    chk(los, 4'h0, "T1 loss cleared");
    $display("Test T1 loss done");
    @(posedge i_clock);
    eq <= 5'h10;
    ext <= 1'b1;
    alos <= 4'hF;
    u_tx.send(128'h0, 4095);
    settle(4);
    chk(los, 4'h0, "ext early loss");
    u_tx.send(128'h0, 1);
    settle(4);
    chk(los, 4'hF, "ext loss");
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    ext <= 1'b0;
    alos <= 4'h0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    settle(2);
    chk({int_n, los}, 5'h10, "second reset");
    $display("Test extended loss done");
    @(posedge i_clock);
    host_mode <= 1'b1;
    ref_sel <= 3'h7;
    rate <= 1'b1;
    eq <= 5'h00;
    apb(1'b1, ADDR_CTRL, 32'h2A02);
    settle(3);
    chk(ch_on, 4'h5, "host channels");
    chk({6'h0, mclk}, {6'h0, SRC_EXT, KHZ_8, KHZ_E1}, "host mclk");
    chk(e1_mode, 1'b1, "host E1 mode");
    rd(ADDR_MCLK, {6'h0, SRC_EXT, KHZ_8, KHZ_E1}, "mclk reg");
    rd(ADDR_CTRL, 32'h2A02, "ctrl readback");
    alos <= 4'hF;
    u_tx.send(128'h0, 32);
    settle(4);
    chk(los, 4'h5, "loss on enabled only");
    $display("Test host mode done");
    tally_and_finish();
  end
endmodule : tb_top
